/* File: logic/amp_switch_regs.svh */
// register offsets, reset values, field positions and codes of the amplifier switch block
//
// Contract
// [R01] gain bit 7 feeds amp one into inverting input
// [R02] gain bit 6 feeds amp one into non-inverting
// [R03] gain bits 5 and 4 read as zero
// [R04] gain bit 3 enables programmable gain
// [R05] gain code 000 is one, else eight times code
// [R06] comparator feed switch follows its control bit
// [R07] amp one pin select forces reference select off
// [R08] amp one disabled opens its feedback switch
// [R09] amp one pin and reference switches follow bits
// [R10] pin on, neg off, feedback on: buffer
// [R11] amp one pin sharing follows enable and selects
// [R12] gain enable closes both gain network switches
// [R13] amp two disabled opens gain and feedback switches
// [R14] amp two pos pin beats feed beats references
// [R15] amp two neg pin opens amp one inverting feed
// [R16] amp two switches follow their own control bits
// [R17] amp two pin sharing follows enable, selects, gain
// [R18] gain plus neg pin bypasses input resistor
// [R19] reference select: none, high, mid, low
// [R20] each amplifier has master enable bit
// [R21] amp two self feedback bit closes feedback path
// [R22] switch enables follow current register values directly; here they are flopped and follow one clock later
`ifndef AMP_SWITCH_REGS_SVH
`define AMP_SWITCH_REGS_SVH

// byte offsets on the register bus
`define AMP_ONE_CTRL_OFS 8'h00
`define AMP_ONE_STAT_OFS 8'h04
`define AMP_TWO_CTRL_OFS 8'h08
`define AMP_TWO_STAT_OFS 8'h0c
`define AMP_TWO_GAIN_OFS 8'h10
`define SWITCH_STAT_OFS 8'h14

// reset values
`define AMP_CTRL_RESET 8'h0c
`define AMP_TWO_GAIN_RESET 8'h00

// writable bits of the gain and cross-link register
`define AMP_TWO_GAIN_WMASK 8'hcf

// bit position of the amplifier output in its status register
`define AMP_OUT_BIT 7

// reference select codes
`define REF_NONE 2'h0
`define REF_HIGH 2'h1
`define REF_MID 2'h2
`define REF_LOW 2'h3

// gain decode: code 0 gives unity, others step by this factor
`define GAIN_STEP 6'h08
`define GAIN_UNITY 6'h01

`endif

/* File: logic/amp_switch_pkg.sv */
// types shared by the amplifier switch matrix control
package amp_switch_pkg;

    // per amplifier control byte, laid out as stored
    typedef struct packed {
        logic comp_feed;
        logic self_feedback_en;
        logic [1:0] reference_sel;
        logic pos_pin_sel;
        logic neg_pin_sel;
        logic out_en;
        logic enable;
    } amp_ctrl_type;

    // gain and cross-link byte
    typedef struct packed {
        logic amp1_to_amp2_inv_en;
        logic amp1_to_amp2_noninv_en;
        logic [1:0] unused;
        logic prog_gain_enable;
        logic [2:0] prog_gain_code;
    } gain_reg_type;

    // reference switches: high, mid, low
    typedef struct packed {
        logic high;
        logic mid;
        logic low;
    } ref_switch_type;

    typedef struct packed {
        logic comparator_feed;
        logic feedback;
        logic pos_pin;
        logic neg_pin;
        ref_switch_type reference;
    } amp_one_switch_type;

    typedef struct packed {
        logic gain_a;
        logic gain_b;
        logic feedback;
        logic pos_pin;
        logic neg_pin;
        logic from_amp1_inv;
        logic from_amp1_noninv;
        ref_switch_type reference;
    } amp_two_switch_type;

    // pins taken from general io
    typedef struct packed {
        logic out_pin;
        logic neg_pin;
        logic pos_pin;
    } pin_claim_type;

    // reference code to switch set, shared by both amplifiers
    function automatic ref_switch_type ref_decode(input logic [1:0] sel);
        ref_decode.high = (sel == 2'h1);
        ref_decode.mid = (sel == 2'h2);
        ref_decode.low = (sel == 2'h3);
    endfunction

endpackage

/* File: logic/amp_one_switch_decode.sv */
// switch and pin decode for the first amplifier
`timescale 1ns/1ns
module amp_one_switch_decode
(
    // control byte
    input wire amp_switch_pkg::amp_ctrl_type ctrl_i,
    // switch and pin results
    output amp_switch_pkg::amp_one_switch_type sw_o,
    output amp_switch_pkg::pin_claim_type pins_o
);

    logic [1:0] ref_eff;

    // pin select wins over the internal reference
    assign ref_eff = ctrl_i.pos_pin_sel ? 2'h0 : ctrl_i.reference_sel; // [R07]

    // switch enables are pure functions of the control byte
    always_comb
    begin
        sw_o.comparator_feed = ctrl_i.comp_feed; // [R06]
        sw_o.feedback = ctrl_i.self_feedback_en & ctrl_i.enable; // [R08] [R10]
        sw_o.pos_pin = ctrl_i.pos_pin_sel; // [R09] [R10]
        sw_o.neg_pin = ctrl_i.neg_pin_sel; // [R09] [R10]
        sw_o.reference = amp_switch_pkg::ref_decode(ref_eff); // [R09] [R19]
    end

    // pin sharing: nothing is taken while disabled
    always_comb
    begin
        pins_o.out_pin = ctrl_i.enable; // [R11] [R20]
        pins_o.pos_pin = ctrl_i.enable & ctrl_i.pos_pin_sel; // [R11]
        pins_o.neg_pin = ctrl_i.enable & ctrl_i.neg_pin_sel; // [R11]
    end

endmodule // amp_one_switch_decode

/* File: logic/amp_two_switch_decode.sv */
// switch and pin decode for the second amplifier
`timescale 1ns/1ns
module amp_two_switch_decode
(
    // control bytes
    input wire amp_switch_pkg::amp_ctrl_type ctrl_i,
    input wire amp_switch_pkg::gain_reg_type gain_i,
    // switch and pin results
    output amp_switch_pkg::amp_two_switch_type sw_o,
    output amp_switch_pkg::pin_claim_type pins_o,
    output logic bypass_o
);

    logic gain_on;
    logic feed_noninv;
    logic [1:0] ref_eff;

    assign gain_on = gain_i.prog_gain_enable & ctrl_i.enable; // [R04] [R12] [R13]
    // priority on the non-inverting input: pin, then amp one feed, then references
    assign feed_noninv = gain_i.amp1_to_amp2_noninv_en & ~ctrl_i.pos_pin_sel; // [R02] [R14]
    assign ref_eff = (ctrl_i.pos_pin_sel | gain_i.amp1_to_amp2_noninv_en) ? 2'h0 : ctrl_i.reference_sel; // [R14]

    always_comb
    begin
        sw_o.gain_a = gain_on; // [R12] [R13]
        sw_o.gain_b = gain_on; // [R12] [R13]
        sw_o.feedback = ctrl_i.self_feedback_en & ctrl_i.enable; // [R13] [R21]
        sw_o.pos_pin = ctrl_i.pos_pin_sel; // [R16]
        sw_o.neg_pin = ctrl_i.neg_pin_sel; // [R16]
        sw_o.from_amp1_inv = gain_i.amp1_to_amp2_inv_en & ~ctrl_i.neg_pin_sel; // [R01] [R15]
        sw_o.from_amp1_noninv = feed_noninv; // [R16]
        sw_o.reference = amp_switch_pkg::ref_decode(ref_eff); // [R16] [R19]
    end

    // pin sharing; gain network also needs the negative pin
    always_comb
    begin
        pins_o.out_pin = ctrl_i.enable; // [R17] [R20]
        pins_o.pos_pin = ctrl_i.enable & ctrl_i.pos_pin_sel; // [R17]
        pins_o.neg_pin = ctrl_i.enable & (ctrl_i.neg_pin_sel | gain_i.prog_gain_enable); // [R17]
        bypass_o = gain_on & ctrl_i.neg_pin_sel; // [R18]
    end

endmodule // amp_two_switch_decode

/* File: logic/amp_switch_matrix_control.sv */
// wishbone register file and registered switch outputs for the two amplifiers
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "amp_switch_regs.svh"
module amp_switch_matrix_control
#(
    parameter int SYNC_STAGES = 3
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog amplifier outputs, asynchronous
    input wire logic amp1_out_i,
    input wire logic amp2_out_i,
    // switch enables
    output amp_switch_pkg::amp_one_switch_type amp1_sw_o,
    output amp_switch_pkg::amp_two_switch_type amp2_sw_o,
    output logic amp2_gain_bypass_o,
    output logic [5:0] prog_gain_value_o,
    // pins taken from general io
    output amp_switch_pkg::pin_claim_type amp1_pins_o,
    output amp_switch_pkg::pin_claim_type amp2_pins_o
);

    // gain value: unity for code zero, else step times code
    // code zero means unity rather than zero; the product fits six bits up to code seven
    function automatic logic [5:0] gain_value(input logic [2:0] code);
        logic [5:0] prod;
        prod = 6'({3'h0, code} * `GAIN_STEP);
        gain_value = (code == 3'h0) ? `GAIN_UNITY : prod; // [R05]
    endfunction

    // merge a byte lane into a stored byte
    // only the low lane has a register behind it; upper lanes are ignored
    function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [7:0] data, input logic sel);
        lane_write = sel ? data : old;
    endfunction

    // ---------------- bus handshake ----------------
    logic req;
    logic wr_hit;
    logic ack_d;
    logic ack_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // a request is answered one cycle after it is seen, ack drops the cycle after
    // holding stb through ack starts no second access until ack has fallen
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    // a write with the low lane off is acknowledged but changes nothing
    assign wr_hit = req & wb_we_i & wb_sel_i[0];

    // ---------------- control registers ----------------
    amp_switch_pkg::amp_ctrl_type amp1_ctrl_d;
    amp_switch_pkg::amp_ctrl_type amp1_ctrl_q;
    amp_switch_pkg::amp_ctrl_type amp2_ctrl_d;
    amp_switch_pkg::amp_ctrl_type amp2_ctrl_q;
    amp_switch_pkg::gain_reg_type gain_d;
    amp_switch_pkg::gain_reg_type gain_q;

    // next values of the software registers
    // a write lands on the edge that takes the request, the same edge that raises ack
    always_comb
    begin
        amp1_ctrl_d = amp1_ctrl_q;
        amp2_ctrl_d = amp2_ctrl_q;
        gain_d = gain_q;
        if (wr_hit)
        begin
            unique case (wb_adr_i)
                `AMP_ONE_CTRL_OFS:
                begin
                    amp1_ctrl_d = lane_write(amp1_ctrl_q, wb_dat_i[7:0], 1'b1); // [R20]
                end
                `AMP_TWO_CTRL_OFS:
                begin
                    amp2_ctrl_d = lane_write(amp2_ctrl_q, wb_dat_i[7:0], 1'b1); // [R20]
                end
                `AMP_TWO_GAIN_OFS:
                begin
                    // unimplemented bits are never stored
                    gain_d = wb_dat_i[7:0] & `AMP_TWO_GAIN_WMASK; // [R03]
                end
                default:
                begin
                    // unmapped and read-only places ignore writes
                    gain_d = gain_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // power-on: both pin selects set, amplifier off, gain byte clear
            amp1_ctrl_q <= `AMP_CTRL_RESET;
            amp2_ctrl_q <= `AMP_CTRL_RESET;
            gain_q <= `AMP_TWO_GAIN_RESET;
        end
        else
        begin
            amp1_ctrl_q <= amp1_ctrl_d;
            amp2_ctrl_q <= amp2_ctrl_d;
            gain_q <= gain_d;
        end
    end

    // ---------------- amplifier output synchronisers ----------------
    // three stages; a change counts only once the last two agree
    logic [SYNC_STAGES-1:0] amp1_sync_d;
    logic [SYNC_STAGES-1:0] amp1_sync_q;
    logic [SYNC_STAGES-1:0] amp2_sync_d;
    logic [SYNC_STAGES-1:0] amp2_sync_q;
    logic amp1_level_d;
    logic amp1_level_q;
    logic amp2_level_d;
    logic amp2_level_q;

    always_comb
    begin
        // the first stage feeds only the second; nothing else reads it
        amp1_sync_d = {amp1_sync_q[SYNC_STAGES-2:0], amp1_out_i};
        amp2_sync_d = {amp2_sync_q[SYNC_STAGES-2:0], amp2_out_i};
        amp1_level_d = amp1_level_q;
        amp2_level_d = amp2_level_q;
        // only the last two stages are compared, never the first
        if (amp1_sync_q[SYNC_STAGES-1] == amp1_sync_q[SYNC_STAGES-2])
        begin
            amp1_level_d = amp1_sync_q[SYNC_STAGES-1];
        end
        if (amp2_sync_q[SYNC_STAGES-1] == amp2_sync_q[SYNC_STAGES-2])
        begin
            amp2_level_d = amp2_sync_q[SYNC_STAGES-1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // reset level matches an idle low output, so no false change follows
            amp1_sync_q <= '0;
            amp2_sync_q <= '0;
            amp1_level_q <= 1'b0;
            amp2_level_q <= 1'b0;
        end
        else
        begin
            amp1_sync_q <= amp1_sync_d;
            amp2_sync_q <= amp2_sync_d;
            amp1_level_q <= amp1_level_d;
            amp2_level_q <= amp2_level_d;
        end
    end

    // ---------------- switch decode ----------------
    // the decoders are pure logic; every forced override is applied there
    amp_switch_pkg::amp_one_switch_type amp1_sw;
    amp_switch_pkg::amp_two_switch_type amp2_sw;
    amp_switch_pkg::pin_claim_type amp1_pins;
    amp_switch_pkg::pin_claim_type amp2_pins;
    logic amp2_bypass;

    amp_one_switch_decode u_amp_one
    (
        .ctrl_i (amp1_ctrl_q),
        .sw_o (amp1_sw),
        .pins_o (amp1_pins)
    );

    amp_two_switch_decode u_amp_two
    (
        .ctrl_i (amp2_ctrl_q),
        .gain_i (gain_q),
        .sw_o (amp2_sw),
        .pins_o (amp2_pins),
        .bypass_o (amp2_bypass)
    );

    // ---------------- output registers ----------------
    // outputs are flopped for clean drive; they trail the register by one cycle
    // limitation: a switch follows its control bit one clock late, not at once
    amp_switch_pkg::amp_one_switch_type amp1_sw_d;
    amp_switch_pkg::amp_one_switch_type amp1_sw_q;
    amp_switch_pkg::amp_two_switch_type amp2_sw_d;
    amp_switch_pkg::amp_two_switch_type amp2_sw_q;
    amp_switch_pkg::pin_claim_type amp1_pins_d;
    amp_switch_pkg::pin_claim_type amp1_pins_q;
    amp_switch_pkg::pin_claim_type amp2_pins_d;
    amp_switch_pkg::pin_claim_type amp2_pins_q;
    logic bypass_d;
    logic bypass_q;
    logic [5:0] gain_val_d;
    logic [5:0] gain_val_q;

    always_comb
    begin
        amp1_sw_d = amp1_sw; // [R22]
        amp2_sw_d = amp2_sw; // [R22]
        amp1_pins_d = amp1_pins;
        amp2_pins_d = amp2_pins;
        bypass_d = amp2_bypass;
        gain_val_d = gain_value(gain_q.prog_gain_code); // [R05]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // in reset every switch is open and no pin is claimed
            amp1_sw_q <= '0;
            amp2_sw_q <= '0;
            amp1_pins_q <= '0;
            amp2_pins_q <= '0;
            bypass_q <= 1'b0;
            gain_val_q <= `GAIN_UNITY;
        end
        else
        begin
            amp1_sw_q <= amp1_sw_d;
            amp2_sw_q <= amp2_sw_d;
            amp1_pins_q <= amp1_pins_d;
            amp2_pins_q <= amp2_pins_d;
            bypass_q <= bypass_d;
            gain_val_q <= gain_val_d;
        end
    end

    // ---------------- switch status word ----------------
    // packed once here so the read mux stays a plain selection
    logic [31:0] sw_status;

    always_comb
    begin
        sw_status = 32'h0000_0000;
        sw_status[6:0] = amp1_sw_q;
        sw_status[17:8] = amp2_sw_q;
        sw_status[18] = bypass_q;
        sw_status[21:19] = amp1_pins_q;
        sw_status[24:22] = amp2_pins_q;
        sw_status[30:25] = gain_val_q;
    end

    // ---------------- acknowledge ----------------
    // one pulse per request; a held strobe waits for ack to fall
    always_comb
    begin
        ack_d = req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
        end
    end

    // ---------------- read data ----------------
    // read data stands only in the cycle in which ack is high
    always_comb
    begin
        // zero outside reads keeps the data bus quiet between accesses
        rdata_d = 32'h0000_0000;
        if (req & ~wb_we_i)
        begin
            unique case (wb_adr_i)
                `AMP_ONE_CTRL_OFS:
                begin
                    // stored select reads back as written; forcing acts on switches only
                    rdata_d[7:0] = amp1_ctrl_q;
                end
                `AMP_ONE_STAT_OFS:
                begin
                    // status carries only the settled amplifier output
                    rdata_d[`AMP_OUT_BIT] = amp1_level_q;
                end
                `AMP_TWO_CTRL_OFS:
                begin
                    rdata_d[7:0] = amp2_ctrl_q;
                end
                `AMP_TWO_STAT_OFS:
                begin
                    rdata_d[`AMP_OUT_BIT] = amp2_level_q;
                end
                `AMP_TWO_GAIN_OFS:
                begin
                    rdata_d[7:0] = gain_q & `AMP_TWO_GAIN_WMASK; // [R03]
                end
                `SWITCH_STAT_OFS:
                begin
                    // live switch state as it stands on the outputs
                    rdata_d = sw_status;
                end
                default:
                begin
                    // unmapped addresses answer with zero
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // every output comes straight from a flip-flop
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign amp1_sw_o = amp1_sw_q;
    assign amp2_sw_o = amp2_sw_q;
    assign amp1_pins_o = amp1_pins_q;
    assign amp2_pins_o = amp2_pins_q;
    assign amp2_gain_bypass_o = bypass_q;
    assign prog_gain_value_o = gain_val_q;

endmodule // amp_switch_matrix_control

/* File: verification/amp_switch_checker_properties.sv */
// port-level checks of the amplifier switch matrix control
`timescale 1ns/1ns
module amp_switch_checker
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // switch and pin results
    input wire amp_switch_pkg::amp_one_switch_type amp1_sw_o,
    input wire amp_switch_pkg::amp_two_switch_type amp2_sw_o,
    input wire logic amp2_gain_bypass_o,
    input wire logic [5:0] prog_gain_value_o,
    input wire amp_switch_pkg::pin_claim_type amp1_pins_o,
    input wire amp_switch_pkg::pin_claim_type amp2_pins_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request counts only on an edge where ack is low
    sequence taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence gain_write_s;
        taken_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10);
    endsequence

    // the switch outputs lag the register by one cycle, hence the two-cycle wait
    ack_single_cycle_a: assert property (taken_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a single pulse after a request");
    gain_decode_a: assert property (gain_write_s |-> ##2 prog_gain_value_o == (($past(wb_dat_i[2:0], 2) == 3'h0) ?
        6'h01 : {$past(wb_dat_i[2:0], 2), 3'h0})) else $error("gain value does not match written code");
    amp1_ref_force_a: assert property (amp1_sw_o.pos_pin |-> amp1_sw_o.reference == 3'h0)
        else $error("amp one reference closed with pin selected");
    amp1_fb_gate_a: assert property (amp1_sw_o.feedback |-> amp1_pins_o.out_pin)
        else $error("amp one feedback closed while disabled");
    amp1_pin_share_a: assert property (amp1_pins_o.neg_pin == (amp1_pins_o.out_pin && amp1_sw_o.neg_pin)
        && amp1_pins_o.pos_pin == (amp1_pins_o.out_pin && amp1_sw_o.pos_pin)) else $error("amp one pin claim wrong");
    amp2_pos_prio_a: assert property (amp2_sw_o.pos_pin || amp2_sw_o.from_amp1_noninv |->
        amp2_sw_o.reference == 3'h0 && !(amp2_sw_o.pos_pin && amp2_sw_o.from_amp1_noninv)) else $error("amp two noninv priority");
    amp2_neg_prio_a: assert property (amp2_sw_o.neg_pin |-> !amp2_sw_o.from_amp1_inv)
        else $error("amp two inverting feed closed with pin selected");
    amp2_gain_pair_a: assert property (amp2_sw_o.gain_a == amp2_sw_o.gain_b)
        else $error("amp two gain switches disagree");
    amp2_disable_a: assert property (amp2_sw_o.gain_a || amp2_sw_o.feedback |-> amp2_pins_o.out_pin)
        else $error("amp two switch closed while disabled");
    amp2_pin_share_a: assert property (amp2_pins_o.neg_pin == (amp2_pins_o.out_pin && (amp2_sw_o.neg_pin
        || amp2_sw_o.gain_a)) && amp2_pins_o.pos_pin == (amp2_pins_o.out_pin && amp2_sw_o.pos_pin)) else $error("amp two pins");
    gain_bypass_a: assert property (amp2_gain_bypass_o == (amp2_sw_o.gain_a && amp2_sw_o.neg_pin))
        else $error("bypass does not follow gain and pin");
    ref_onehot_a: assert property ($onehot0(amp1_sw_o.reference) && $onehot0(amp2_sw_o.reference))
        else $error("more than one reference closed");
endmodule // amp_switch_checker

bind amp_switch_matrix_control amp_switch_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .amp1_sw_o(amp1_sw_o), .amp2_sw_o(amp2_sw_o), .amp2_gain_bypass_o(amp2_gain_bypass_o),
    .prog_gain_value_o(prog_gain_value_o), .amp1_pins_o(amp1_pins_o), .amp2_pins_o(amp2_pins_o));

/* File: verification/testbench.sv */
// self-checking bench for the amplifier switch matrix control
`timescale 1ns/1ns
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic amp1_out_i = 1'b0;
    logic amp2_out_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    amp_switch_pkg::amp_one_switch_type amp1_sw_o;
    amp_switch_pkg::amp_two_switch_type amp2_sw_o;
    logic amp2_gain_bypass_o;
    logic [5:0] prog_gain_value_o;
    amp_switch_pkg::pin_claim_type amp1_pins_o;
    amp_switch_pkg::pin_claim_type amp2_pins_o;
    int miscompares = 0;
    int cmp_count = 0;
    logic [3:0] bus_sel = 4'hf;

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    amp_switch_matrix_control #(.SYNC_STAGES(3)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .amp1_out_i(amp1_out_i), .amp2_out_i(amp2_out_i),
        .amp1_sw_o(amp1_sw_o), .amp2_sw_o(amp2_sw_o), .amp2_gain_bypass_o(amp2_gain_bypass_o),
        .prog_gain_value_o(prog_gain_value_o), .amp1_pins_o(amp1_pins_o), .amp2_pins_o(amp2_pins_o));

    // compare one value and count the outcome
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one classic cycle; held until ack is sampled, then one idle cycle so ack can fall
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] data);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= bus_sel;
        wb_dat_i <= dat;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        // a missing ack counts once and ends the run
        if (wb_ack_o !== 1'b1)
        begin
            miscompares++;
            end_of_test();
        end
        data = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] unused;
        wb_cycle(1'b1, adr, dat, unused);
    endtask

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] data;
        wb_cycle(1'b0, adr, 32'h0, data);
        check(data, exp);
    endtask

    // program both controls and the gain byte, then compare every switch and pin output
    task automatic run_case(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] g, input logic [6:0] e1,
        input logic [9:0] e2, input logic [2:0] p1, input logic [2:0] p2, input logic eb);
        wr(8'h00, {24'h0, c1});
        wr(8'h08, {24'h0, c2});
        wr(8'h10, {24'h0, g});
        check(32'(amp1_sw_o), {25'h0, e1});
        check(32'(amp2_sw_o), {22'h0, e2});
        check(32'(amp1_pins_o), {29'h0, p1});
        check(32'(amp2_pins_o), {29'h0, p2});
        check({31'h0, amp2_gain_bypass_o}, {31'h0, eb});
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        // outputs after reset follow the power-on register values
        check(32'(amp1_sw_o), 32'h18);
        check(32'(amp2_sw_o), 32'h60);
        rd_check(8'h00, 32'h0c);
        rd_check(8'h08, 32'h0c);
        rd_check(8'h10, 32'h00);
        // every gain code, enable set
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h10, 32'h08 | 32'(c));
            check(32'(prog_gain_value_o), 32'(c == 0 ? 1 : 8 * c));
        end
        run_case(8'hd9, 8'h64, 8'h0b, 7'h70, 10'h022, 3'h5, 3'h0, 1'b0);
        run_case(8'h74, 8'h55, 8'hcf, 7'h09, 10'h3a8, 3'h0, 3'h6, 1'b1);
        run_case(8'h21, 8'h39, 8'hf8, 7'h02, 10'h350, 3'h4, 3'h7, 1'b0);
        rd_check(8'h10, 32'hc8);
        run_case(8'h11, 8'h11, 8'h04, 7'h04, 10'h004, 3'h4, 3'h4, 1'b0);
        // a write with the low lane off changes nothing
        bus_sel = 4'he;
        wr(8'h10, 32'h00);
        bus_sel = 4'hf;
        rd_check(8'h10, 32'h04);
        // switch word: both high references, both out pins, gain 32
        rd_check(8'h14, 32'h4120_0404);
        // unmapped place: write dropped, read zero
        wr(8'h20, 32'hff);
        rd_check(8'h20, 32'h0);
        // amplifier outputs pass the synchroniser into the status bytes
        amp1_out_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd_check(8'h04, 32'h80);
        rd_check(8'h0c, 32'h00);
        amp2_out_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd_check(8'h0c, 32'h80);
        // reset in mid-run brings back the power-on values
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(32'(amp1_sw_o), 32'h18);
        check(32'(prog_gain_value_o), 32'h01);
        rd_check(8'h10, 32'h00);
        end_of_test();
    end
endmodule // testbench
